/* File: rtl/ncs_csr.sv */
// Lower eleven bits of the network controller command and status word, plus its control logic.
// Assumes a host on a strobe port and engine events arriving as pins from outside.
// Notes on behaviour
// - Receive flag set on final-buffer writeback
// - Event flags clear on write one, stop
// - Transmit flag set on writeback or failure
// - Init-done flag set after block fetched
// - Flag set with enable raises interrupt
// - Receiver-on read-only, cleared by disable/error/stop
// - Transmitter-on set by run if enabled; the code also needs the initialize bit set
// - Transmitter-on read-only, cleared by disable/errors/stop
// - Transmit demand triggers immediate ring access
// - Demand write-one only, cleared when used
// - Stop halts everything like reset
// - Stop wins over run and initialize
// - Stop set by reset, write-one, cleared by start
// - Run enables traffic, clears stop
// - Initialize starts fetch, clears stop, write-one
// - Receiver-on set by run after init fetch
// - Interrupt pin low on flag and enable
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ncs_csr #(
  parameter int unsigned FETCH_LEN = ncs_pkg::FETCH_CYCLES
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [ncs_pkg::ADDR_W-1:0] ADDR,
  input wire logic [ncs_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ncs_pkg::DATA_W-1:0] RDATA,
  // Engine events, asynchronous levels
  input wire logic RX_LAST_WB,
  input wire logic TX_LAST_WB,
  input wire logic TX_FAIL,
  input wire logic MEM_ERR,
  input wire logic TX_UNDERFLOW_ERROR_BUFFER_ERROR,
  // Engine controls
  output logic RUN_ENABLE,
  output logic HALT,
  output logic INIT_FETCH,
  output logic TX_POLL_NOW,
  // Interrupt, active low
  output logic IRQ_N
);
  logic rst_all;
  logic [4:0] ev_rise;
  logic ev_rx;
  logic ev_tx_wb;
  logic ev_tx_fail;
  logic ev_memory_error;
  logic ev_txerr;
  logic wr_csw;
  logic wr_mode;
  logic w_stop;
  logic w_run;
  logic w_init;
  logic set_stop;
  logic set_run;
  logic set_init;
  logic init_done_ev;
  logic rx_event_flag_q;
  logic tx_event_flag_q;
  logic init_done_flag_q;
  logic receiver_on_q;
  logic transmitter_on_q;
  logic transmit_demand_q;
  logic stop_q;
  logic run_bit_q;
  logic init_q;
  logic irq_enable_q;
  logic receive_disable_q;
  logic transmit_disable_q;
  logic block_read_q;
  logic irq_flag;
  logic [ncs_pkg::DATA_W-1:0] csw_view;
  logic [ncs_pkg::DATA_W-1:0] rd_mux;
  logic [ncs_pkg::DATA_W-1:0] rdata_q;
  logic [7:0] fetch_cnt_q;
  logic demand_ack_q;
  ncs_pkg::ncs_init_t state_q;
  ncs_pkg::ncs_init_t state_d;

  // Event pins come from other engines and pass two flops first
  ncs_pulse_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .async_in({TX_UNDERFLOW_ERROR_BUFFER_ERROR, MEM_ERR, TX_FAIL, TX_LAST_WB, RX_LAST_WB}),
    .rise(ev_rise)
  );
  assign ev_rx = ev_rise[0];
  assign ev_tx_wb = ev_rise[1];
  assign ev_tx_fail = ev_rise[2];
  assign ev_memory_error = ev_rise[3];
  assign ev_txerr = ev_rise[4] | ev_memory_error;

  // Write decode
  assign wr_csw = WR && (ADDR == ncs_pkg::ADDR_CSW);
  assign wr_mode = WR && (ADDR == ncs_pkg::ADDR_MODE);
  assign w_stop = wr_csw && WDATA[ncs_pkg::B_STOP];
  assign w_run = wr_csw && WDATA[ncs_pkg::B_RUN];
  assign w_init = wr_csw && WDATA[ncs_pkg::B_INIT];
  // Stop overrides run and initialize in the same write
  assign set_stop = w_stop;
  assign set_run = w_run && !w_stop;
  assign set_init = w_init && !w_stop;
  // Stop acts exactly like the reset pin on everything it touches
  assign rst_all = SYS_RST || set_stop;
  assign init_done_ev = (state_q == ncs_pkg::NCS_FETCH) && (fetch_cnt_q == 8'(FETCH_LEN - 1));

  // Initialization fetch engine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ncs_pkg::NCS_IDLE: begin
        if (set_init) begin
          state_d = ncs_pkg::NCS_FETCH;
        end
      end
      ncs_pkg::NCS_FETCH: begin
        if (init_done_ev) begin
          state_d = ncs_pkg::NCS_DONE;
        end
      end
      ncs_pkg::NCS_DONE: begin
        if (set_init) begin
          state_d = ncs_pkg::NCS_FETCH;
        end
      end
      default: state_d = ncs_pkg::NCS_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      state_q <= ncs_pkg::NCS_IDLE;
      fetch_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == ncs_pkg::NCS_FETCH) begin
        fetch_cnt_q <= fetch_cnt_q + 8'h01;
      end else begin
        fetch_cnt_q <= '0;
      end
    end
  end

  // Control bits: stop, run, initialize, enable
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      stop_q <= 1'b1;
      run_bit_q <= 1'b0;
      init_q <= 1'b0;
      irq_enable_q <= 1'b0;
    end else begin
      if (set_run || set_init) begin
        stop_q <= 1'b0;
      end
      if (set_run) begin
        run_bit_q <= 1'b1;
      end
      if (set_init) begin
        init_q <= 1'b1;
      end
      if (wr_csw && !stop_q) begin
        irq_enable_q <= WDATA[ncs_pkg::B_IEN];
      end else if (wr_csw && (set_run || set_init)) begin
        irq_enable_q <= WDATA[ncs_pkg::B_IEN];
      end
    end
  end

  // Mode bits; only a real reset clears them, they stand in for the fetched block
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      receive_disable_q <= 1'b0;
      transmit_disable_q <= 1'b0;
    end else if (wr_mode) begin
      receive_disable_q <= WDATA[ncs_pkg::B_RXDIS];
      transmit_disable_q <= WDATA[ncs_pkg::B_TXDIS];
    end
  end

  // Event flags: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      rx_event_flag_q <= 1'b0;
      tx_event_flag_q <= 1'b0;
      init_done_flag_q <= 1'b0;
      block_read_q <= 1'b0;
    end else begin
      if (ev_rx) begin
        rx_event_flag_q <= 1'b1;
      end else if (wr_csw && WDATA[ncs_pkg::B_RXEV]) begin
        rx_event_flag_q <= 1'b0;
      end
      if (ev_tx_wb || ev_tx_fail) begin
        tx_event_flag_q <= 1'b1;
      end else if (wr_csw && WDATA[ncs_pkg::B_TXEV]) begin
        tx_event_flag_q <= 1'b0;
      end
      if (init_done_ev) begin
        init_done_flag_q <= 1'b1;
        block_read_q <= 1'b1;
      end else if (wr_csw && WDATA[ncs_pkg::B_INIT_DONE_FLAG]) begin
        init_done_flag_q <= 1'b0;
      end
    end
  end

  // Receiver and transmitter on indications; read-only, set by a run write and cleared by a stop write
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      receiver_on_q <= 1'b0;
      transmitter_on_q <= 1'b0;
    end else begin
      if (ev_memory_error || (init_done_ev && receive_disable_q)) begin
        receiver_on_q <= 1'b0;
      end else if (set_run && !receive_disable_q && block_read_q) begin
        receiver_on_q <= 1'b1;
      end
      if (ev_txerr || (init_done_ev && transmit_disable_q)) begin
        transmitter_on_q <= 1'b0;
      end else if (set_run && !transmit_disable_q && (init_q || block_read_q)) begin
        transmitter_on_q <= 1'b1;
      end
    end
  end

  // Transmit demand: write-one only, cleared once the poll request is taken
  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      transmit_demand_q <= 1'b0;
      demand_ack_q <= 1'b0;
    end else begin
      demand_ack_q <= transmit_demand_q && transmitter_on_q;
      if (wr_csw && WDATA[ncs_pkg::B_TRANSMIT_DEMAND]) begin
        transmit_demand_q <= 1'b1;
      end else if (demand_ack_q) begin
        transmit_demand_q <= 1'b0;
      end
    end
  end
  // Demand only shortens the wait; normal polling lives in the transmit engine
  assign TX_POLL_NOW = transmit_demand_q && transmitter_on_q && !demand_ack_q;

  // Interrupt flag and pin
  assign irq_flag = rx_event_flag_q | tx_event_flag_q | init_done_flag_q;
  assign IRQ_N = ~(irq_flag & irq_enable_q);

  // Engine controls
  assign RUN_ENABLE = run_bit_q;
  assign HALT = stop_q;
  assign INIT_FETCH = (state_q == ncs_pkg::NCS_FETCH);

  // Read path, one cycle latency; unmapped addresses read zero
  always_comb begin
    csw_view = ncs_pkg::ZERO16;
    csw_view[ncs_pkg::B_INIT] = init_q;
    csw_view[ncs_pkg::B_RUN] = run_bit_q;
    csw_view[ncs_pkg::B_STOP] = stop_q;
    csw_view[ncs_pkg::B_TRANSMIT_DEMAND] = transmit_demand_q;
    csw_view[ncs_pkg::B_TRANSMITTER_ON] = transmitter_on_q;
    csw_view[ncs_pkg::B_RECEIVER_ON] = receiver_on_q;
    csw_view[ncs_pkg::B_IEN] = irq_enable_q;
    csw_view[ncs_pkg::B_IRQ] = irq_flag;
    csw_view[ncs_pkg::B_INIT_DONE_FLAG] = init_done_flag_q;
    csw_view[ncs_pkg::B_TXEV] = tx_event_flag_q;
    csw_view[ncs_pkg::B_RXEV] = rx_event_flag_q;
  end
  assign rd_mux = (ADDR == ncs_pkg::ADDR_CSW) ? csw_view :
                  (ADDR == ncs_pkg::ADDR_MODE) ?
                  {14'h0000, transmit_disable_q, receive_disable_q} : ncs_pkg::ZERO16;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rdata_q <= ncs_pkg::ZERO16;
    end else if (RD) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= ncs_pkg::ZERO16;
    end
  end
  assign RDATA = rdata_q;
endmodule // ncs_csr

/* File: rtl/ncs_pkg.sv */
// Package for the command and status word block: bit positions, reset value, states.
// Assumes a 16-bit register reached over a plain strobe port.
package ncs_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 2;
  // Register indices
  localparam logic [1:0] ADDR_CSW = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_EVT = 2'h2;
  // Bit positions in the command and status word
  localparam int unsigned B_INIT = 0;
  localparam int unsigned B_RUN = 1;
  localparam int unsigned B_STOP = 2;
  localparam int unsigned B_TRANSMIT_DEMAND = 3;
  localparam int unsigned B_TRANSMITTER_ON = 4;
  localparam int unsigned B_RECEIVER_ON = 5;
  localparam int unsigned B_IEN = 6;
  localparam int unsigned B_IRQ = 7;
  localparam int unsigned B_INIT_DONE_FLAG = 8;
  localparam int unsigned B_TXEV = 9;
  localparam int unsigned B_RXEV = 10;
  // Bit positions in the mode register
  localparam int unsigned B_RXDIS = 0;
  localparam int unsigned B_TXDIS = 1;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // Status word just after reset: only stop set
  localparam logic [15:0] CSW_RESET = 16'h0004;
  // Initialization engine states, Gray along the path
  typedef enum logic [1:0] {
    NCS_IDLE = 2'b00,
    NCS_FETCH = 2'b01,
    NCS_DONE = 2'b11
  } ncs_init_t;
  localparam int unsigned FETCH_CYCLES = 12;
endpackage

/* File: rtl/ncs_pulse_sync.sv */
// Two-flop synchroniser for asynchronous event pins, with a rising edge pulse.
// Assumes inputs are levels from outside the CLOCK domain.
`timescale 1ns/1ps
module ncs_pulse_sync #(
  parameter int unsigned WIDTH = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Async levels and synchronous edges
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] last_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign rise = sync_q & ~last_q;
endmodule // ncs_pulse_sync

/* File: testbench/ncs_csr_properties.sv */
// Port checker for the command and status word block.
// Assumes it is bound to ncs_csr and sees only its ports.
`timescale 1ns/1ps
module ncs_csr_properties #(
  parameter int unsigned FETCH_LEN = 12
) (
  // Clock, reset and register port
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic [ncs_pkg::ADDR_W-1:0] ADDR,
  input wire logic [ncs_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [ncs_pkg::DATA_W-1:0] RDATA,
  // Controls and interrupt
  input wire logic RUN_ENABLE,
  input wire logic HALT,
  input wire logic INIT_FETCH,
  input wire logic TX_POLL_NOW,
  input wire logic IRQ_N
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Slack over the fetch length covers the flag register stage
  localparam int FMAX = FETCH_LEN + 4;
  wire csw_wr = WR && ADDR == ncs_pkg::ADDR_CSW;
  property p_reset;
    disable iff (1'b0) SYS_RST |=> HALT && !RUN_ENABLE && !INIT_FETCH && IRQ_N;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_rd_idle;
    !RD |=> RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_stop;
    csw_wr && WDATA[2] |=> HALT && !RUN_ENABLE && !INIT_FETCH && IRQ_N;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not win");
  property p_init;
    csw_wr && HALT && WDATA[0] && !WDATA[2] |=> INIT_FETCH && !HALT;
  endproperty
  a_init: assert property (p_init) else $error("init did not start");
  property p_run;
    csw_wr && WDATA[1] && !WDATA[2] |=> RUN_ENABLE && !HALT;
  endproperty
  a_run: assert property (p_run) else $error("run not taken");
  property p_halt_hold;
    HALT && !(csw_wr && |WDATA[1:0]) |=> HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("stop left early");
  property p_fetch;
    $rose(INIT_FETCH) |-> ##[1:FMAX] !INIT_FETCH;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch never ends");
  property p_poll;
    TX_POLL_NOW |-> RUN_ENABLE ##1 !TX_POLL_NOW;
  endproperty
  a_poll: assert property (p_poll) else $error("poll pulse wrong");
  property p_irq_halt;
    !IRQ_N |-> !HALT;
  endproperty
  a_irq_halt: assert property (p_irq_halt) else $error("interrupt while stopped");
endmodule // ncs_csr_properties

/* File: testbench/ncs_csr_tb.sv */
// Self-checking bench for the command and status word block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module ncs_csr_tb;
  // Short fetch keeps the run brief
  localparam int unsigned FL = 6;
  logic clock = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000, rdata, v;
  logic [4:0] ev = 5'h00;
  logic run_enable, halt, init_fetch, tx_poll_now, irq_n;
  int errors = 0, n_checks = 0, cyc = 0, k;
  integer seed = 32'hc7e3;
  always #2.5 clock = ~clock;
  ncs_csr #(.FETCH_LEN(FL)) ncs_csr_inst (.CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX_LAST_WB(ev[0]), .TX_LAST_WB(ev[1]),
    .TX_FAIL(ev[2]), .MEM_ERR(ev[3]), .TX_UNDERFLOW_ERROR_BUFFER_ERROR(ev[4]), .RUN_ENABLE(run_enable),
    .HALT(halt), .INIT_FETCH(init_fetch), .TX_POLL_NOW(tx_poll_now), .IRQ_N(irq_n));
  function automatic logic [15:0] exp_flags(input logic [2:0] f, input logic ien);
    return {5'h00, f, |f, ien, 6'h00};
  endfunction
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clock);
    ev[i] <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic do_init;
    wr_reg(2'h0, 16'h0041);
    `CHK({init_fetch, halt}, 2'b10)
    for (k = 0; k < 40 && init_fetch === 1'b1; k++) @(posedge clock);
    #1;
    `CHK(init_fetch, 1'b0)
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors++;
      finish_test;
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(2'h0);
    `CHK(v, 16'h0004)
    for (int a = 2; a < 4; a++) begin
      rd_reg(a[1:0]);
      `CHK(v, 16'h0000)
    end
    wr_reg(2'h0, 16'h0007);
    rd_reg(2'h0);
    `CHK(v, 16'h0004)
    wr_reg(2'h1, 16'h0000);
    do_init();
    rd_reg(2'h0);
    `CHK(v & 16'h07FE, exp_flags(3'b001, 1'b1))
    `CHK(irq_n, 1'b0)
    // Enable takes bit 6 of every command word write without stop made while not stopped, so these writes carry bit 6 to keep it set
    wr_reg(2'h0, 16'h0142);
    rd_reg(2'h0);
    `CHK(v & 16'hFFFE, 16'h0072)
    `CHK({irq_n, run_enable}, 2'b11)
    wr_reg(2'h0, 16'h0040);
    rd_reg(2'h0);
    `CHK(v & 16'hFFFE, 16'h0072)
    for (int i = 0; i < 6; i++) begin
      k = {$random(seed)} % 3;
      pulse(k);
      rd_reg(2'h0);
      `CHK(v & 16'h07C0, exp_flags({k == 0, k != 0, 1'b0}, 1'b1))
      `CHK(irq_n, 1'b0)
      wr_reg(2'h0, 16'h0640);
      rd_reg(2'h0);
      `CHK(v & 16'h07C0, exp_flags(3'b000, 1'b1))
    end
    wr_reg(2'h0, 16'h0048);
    for (k = 0; k < 10 && tx_poll_now !== 1'b1; k++) @(negedge clock);
    `CHK(tx_poll_now, 1'b1)
    repeat (3) @(posedge clock);
    rd_reg(2'h0);
    `CHK(v & 16'h0008, 16'h0000)
    pulse(3);
    rd_reg(2'h0);
    `CHK(v & 16'h0030, 16'h0000)
    wr_reg(2'h0, 16'h0004);
    rd_reg(2'h0);
    `CHK(v, 16'h0004)
    wr_reg(2'h1, 16'h0001);
    do_init();
    wr_reg(2'h0, 16'h0102);
    rd_reg(2'h0);
    `CHK(v & 16'h0030, 16'h0010)
    pulse(4);
    rd_reg(2'h0);
    `CHK(v & 16'h0030, 16'h0000)
    finish_test;
  end
endmodule // ncs_csr_tb
bind ncs_csr ncs_csr_properties #(.FETCH_LEN(FETCH_LEN)) ncs_csr_properties_inst (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .RUN_ENABLE(RUN_ENABLE), .HALT(HALT), .INIT_FETCH(INIT_FETCH),
  .TX_POLL_NOW(TX_POLL_NOW), .IRQ_N(IRQ_N));
